// ==== src/dcd_pkg.sv ====
// Constants for the two-channel DMA register block: register indices, fields, reset values.
// Assumes an APB master with 32-bit data; each 8-bit register sits in the low byte of a word.
package dcd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SRC_LOW = 6'h20;
  localparam logic [5:0] IDX_SRC_HIGH = 6'h21;
  localparam logic [5:0] IDX_SRC_BANK = 6'h22;
  localparam logic [5:0] IDX_DST_LOW = 6'h23;
  localparam logic [5:0] IDX_DST_HIGH = 6'h24;
  localparam logic [5:0] IDX_DST_BANK = 6'h25;
  localparam logic [5:0] IDX_CNT0_LOW = 6'h26;
  localparam logic [5:0] IDX_CNT0_HIGH = 6'h27;
  localparam logic [5:0] IDX_MEM1_LOW = 6'h28;
  localparam logic [5:0] IDX_MEM1_HIGH = 6'h29;
  localparam logic [5:0] IDX_MEM1_BANK = 6'h2a;
  localparam logic [5:0] IDX_IO1_LOW = 6'h2b;
  localparam logic [5:0] IDX_IO1_HIGH = 6'h2c;
  localparam logic [5:0] IDX_CNT1_LOW = 6'h2e;
  localparam logic [5:0] IDX_CNT1_HIGH = 6'h2f;
  localparam logic [5:0] IDX_ENABLE = 6'h30;
  localparam logic [5:0] IDX_MODE = 6'h31;
  localparam logic [5:0] IDX_WAIT_CTRL = 6'h32;

  // Reset values
  localparam logic [7:0] WAIT_CTRL_RST = 8'hf0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] ENABLE_RST = 2'h0;

  // Wait control fields
  localparam int MEM_WAIT_LSB = 6;
  localparam int IO_WAIT_LSB = 4;
  localparam int SENSE_CH1_BIT = 3;
  localparam int SENSE_CH0_BIT = 2;
  localparam int DIR1_LSB = 0;

  // Mode register fields
  localparam int DST_MODE_LSB = 4;
  localparam int SRC_MODE_LSB = 2;
  localparam int BURST_BIT = 1;

  // Address step modes
  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;
  localparam logic [1:0] STEP_IO = 2'h3;

  // Request source codes on address bits 17:16
  localparam logic [1:0] SEL_EXT = 2'h0;
  localparam logic [1:0] SEL_SER0 = 2'h1;
  localparam logic [1:0] SEL_SER1 = 2'h2;

  // Strobe cycles: memory 1 + waits, I/O 1 + (1 + code) waits
  localparam logic [2:0] MEM_BASE_CYCLES = 3'h1;
  localparam logic [2:0] IO_BASE_CYCLES = 3'h2;

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;

  typedef enum logic [2:0] {
    DCD_IDLE = 3'b001,
    DCD_READ = 3'b010,
    DCD_WRITE = 3'b100
  } dcd_state_t;
endpackage : dcd_pkg

// ==== src/dcd_dma_regs.sv ====
// Two-channel DMA engine with its register file, an APB slave and a byte FIFO in the data path.
// Assumes a byte-wide system bus that completes each strobe in the programmed wait cycles.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : dcd_fifo

////////////////////////////////////////////////////////////////////////////////
module dcd_dma_regs
  import dcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Requests
  input wire logic ext_request_ch0_n,
  input wire logic ext_request_ch1_n,
  input wire logic serial0_rx_full,
  input wire logic serial1_rx_full,
  input wire logic serial0_tx_empty,
  input wire logic serial1_tx_empty,
  // System bus master
  output logic bus_own_q,
  output logic bus_strobe_q,
  output logic bus_write_q,
  output logic bus_io_q,
  output logic [19:0] bus_addr_q,
  output logic [7:0] bus_wdata_q,
  input wire logic [7:0] bus_rdata
);
  // Registers
  logic [18:0] src0_q;
  logic [18:0] dst0_q;
  logic [15:0] cnt0_q;
  logic [19:0] mem1_q;
  logic [15:0] io1_q;
  logic [15:0] cnt1_q;
  logic [1:0] enable_q;
  logic [7:0] mode_q;
  logic [7:0] wait_q;
  // Engine
  dcd_state_t state_q;
  logic ch_q;
  logic [15:0] rd_left_q;
  logic [2:0] acc_cnt_q;
  logic [2:0] pin0_sync_q;
  logic [2:0] pin1_sync_q;
  logic pend0_q;
  logic pend1_q;

  function automatic logic [19:0] step_addr(input logic [19:0] a, input logic [1:0] m);
    case (m)
      STEP_INC: step_addr = a + 20'h00001;
      STEP_DEC: step_addr = a - 20'h00001;
      default: step_addr = a;
    endcase
  endfunction : step_addr

  function automatic logic [2:0] acc_load(input logic io, input logic [7:0] w);
    // Strobe length minus one
    acc_load = io ? (IO_BASE_CYCLES + {1'b0, w[IO_WAIT_LSB+:2]} - 3'h1)
                  : (MEM_BASE_CYCLES + {1'b0, w[MEM_WAIT_LSB+:2]} - 3'h1);
  endfunction : acc_load

  function automatic logic pick_req(input logic [1:0] sel, input logic ext, input logic s0,
                                    input logic s1);
    case (sel)
      SEL_EXT: pick_req = ext;
      SEL_SER0: pick_req = s0;
      SEL_SER1: pick_req = s1;
      default: pick_req = 1'b0;
    endcase
  endfunction : pick_req

  //////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait state so read data comes from a flop
  logic [5:0] idx;
  logic acc_phase;
  logic wr_en;
  logic hit;
  logic [7:0] rd_byte;

  assign idx = paddr[7:2];
  assign acc_phase = psel && penable;
  assign wr_en = acc_phase && pready_q && pwrite && pstrb[0] && hit;

  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      IDX_SRC_LOW: rd_byte = src0_q[7:0];
      IDX_SRC_HIGH: rd_byte = src0_q[15:8];
      IDX_SRC_BANK: rd_byte = {5'h00, src0_q[18:16]};
      IDX_DST_LOW: rd_byte = dst0_q[7:0];
      IDX_DST_HIGH: rd_byte = dst0_q[15:8];
      IDX_DST_BANK: rd_byte = {5'h00, dst0_q[18:16]};
      IDX_CNT0_LOW: rd_byte = cnt0_q[7:0];
      IDX_CNT0_HIGH: rd_byte = cnt0_q[15:8];
      IDX_MEM1_LOW: rd_byte = mem1_q[7:0];
      IDX_MEM1_HIGH: rd_byte = mem1_q[15:8];
      IDX_MEM1_BANK: rd_byte = {4'h0, mem1_q[19:16]};
      IDX_IO1_LOW: rd_byte = io1_q[7:0];
      IDX_IO1_HIGH: rd_byte = io1_q[15:8];
      IDX_CNT1_LOW: rd_byte = cnt1_q[7:0];
      IDX_CNT1_HIGH: rd_byte = cnt1_q[15:8];
      IDX_ENABLE: rd_byte = {5'h00, bus_own_q, enable_q};
      IDX_MODE: rd_byte = mode_q;
      IDX_WAIT_CTRL: rd_byte = wait_q;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc_phase && !pready_q;
      pslverr_q <= acc_phase && !pready_q && !hit;
      prdata_q <= (acc_phase && !pready_q && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_phase && !pready_q |=> pready_q ##1 !pready_q) else $error("apb answer not one wait");
  bank_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q && !pwrite && idx == IDX_SRC_BANK |-> prdata_q[7:3] == 5'h00)
    else $error("source bank upper bits not zero");

  //////////////////////////////////////////////////////////////////////////////
  // Request inputs
  logic pin0_fall;
  logic pin1_fall;
  logic req0;
  logic req1;
  logic ext0;
  logic ext1;
  logic src_io;
  logic dst_io;
  logic start0;
  logic start1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_sync_q <= 3'h7;
      pin1_sync_q <= 3'h7;
    end else begin
      pin0_sync_q <= {pin0_sync_q[1:0], ext_request_ch0_n};
      pin1_sync_q <= {pin1_sync_q[1:0], ext_request_ch1_n};
    end
  end

  assign pin0_fall = pin0_sync_q[2] && !pin0_sync_q[1];
  assign pin1_fall = pin1_sync_q[2] && !pin1_sync_q[1];

  // edge latch, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend0_q <= 1'b0;
      pend1_q <= 1'b0;
    end else begin
      pend0_q <= pin0_fall || (pend0_q && !start0);
      pend1_q <= pin1_fall || (pend1_q && !start1);
    end
  end

  edge_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin0_fall |=> pend0_q) else $error("edge request lost");

  // edge or level per sense bit
  assign ext0 = wait_q[SENSE_CH0_BIT] ? pend0_q : !pin0_sync_q[1];
  assign ext1 = wait_q[SENSE_CH1_BIT] ? pend1_q : !pin1_sync_q[1];
  assign src_io = (mode_q[SRC_MODE_LSB+:2] == STEP_IO);
  assign dst_io = (mode_q[DST_MODE_LSB+:2] == STEP_IO);

  always_comb begin
    if (src_io) begin
      req0 = pick_req(src0_q[17:16], ext0, serial0_rx_full, serial1_rx_full);
    end else if (dst_io) begin
      req0 = pick_req(dst0_q[17:16], ext0, serial0_tx_empty, serial1_tx_empty);
    end else begin
      req0 = 1'b1;
    end
  end
  assign req1 = ext1;
  assign start0 = (state_q == DCD_IDLE) && enable_q[0] && req0;
  assign start1 = (state_q == DCD_IDLE) && !start0 && enable_q[1] && req1;

  //////////////////////////////////////////////////////////////////////////////
  // Engine: reads fill the FIFO, writes drain it
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic launch_rd;
  logic launch_wr;
  logic acc_done;
  logic rd_done;
  logic wr_done;
  logic burst;
  logic cur_rd_io;
  logic cur_wr_io;
  logic [19:0] cur_rd_addr;
  logic [19:0] cur_wr_addr;
  logic [1:0] cur_rd_step;
  logic [1:0] cur_wr_step;

  assign burst = mode_q[BURST_BIT];
  assign acc_done = bus_strobe_q && (acc_cnt_q == 3'h0);
  assign rd_done = acc_done && !bus_write_q;
  assign wr_done = acc_done && bus_write_q;
  assign launch_rd = (state_q == DCD_READ) && !bus_strobe_q && (rd_left_q != 16'h0000)
                     && fifo_in_ready;
  assign launch_wr = (state_q == DCD_WRITE) && !bus_strobe_q && fifo_out_valid;

  // channel 1 direction and memory step
  always_comb begin
    if (!ch_q) begin
      cur_rd_io = src_io;
      cur_wr_io = dst_io;
      cur_rd_addr = {1'b0, src0_q};
      cur_wr_addr = {1'b0, dst0_q};
      cur_rd_step = mode_q[SRC_MODE_LSB+:2];
      cur_wr_step = mode_q[DST_MODE_LSB+:2];
    end else if (!wait_q[DIR1_LSB+1]) begin
      cur_rd_io = 1'b0;
      cur_wr_io = 1'b1;
      cur_rd_addr = mem1_q;
      cur_wr_addr = {4'h0, io1_q};
      cur_rd_step = {1'b0, wait_q[DIR1_LSB]};
      cur_wr_step = STEP_IO;
    end else begin
      cur_rd_io = 1'b1;
      cur_wr_io = 1'b0;
      cur_rd_addr = {4'h0, io1_q};
      cur_wr_addr = mem1_q;
      cur_rd_step = STEP_IO;
      cur_wr_step = {1'b0, wait_q[DIR1_LSB]};
    end
  end

  // burst holds the bus, cycle steal moves one byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DCD_IDLE;
      ch_q <= 1'b0;
      rd_left_q <= 16'h0000;
      bus_own_q <= 1'b0;
    end else begin
      case (state_q)
        DCD_IDLE: begin
          if (start0 && cnt0_q != 16'h0000) begin
            state_q <= DCD_READ;
            ch_q <= 1'b0;
            rd_left_q <= burst ? cnt0_q : 16'h0001;
            bus_own_q <= 1'b1;
          end else if (start1 && cnt1_q != 16'h0000) begin
            state_q <= DCD_READ;
            ch_q <= 1'b1;
            rd_left_q <= 16'h0001;
            bus_own_q <= 1'b1;
          end
        end
        DCD_READ: begin
          if (rd_done) begin
            rd_left_q <= rd_left_q - 16'h0001;
          end else if (!bus_strobe_q && !launch_rd) begin
            state_q <= DCD_WRITE;
          end
        end
        DCD_WRITE: begin
          if (!bus_strobe_q && !fifo_out_valid) begin
            if (rd_left_q != 16'h0000) begin
              state_q <= DCD_READ;
            end else begin
              state_q <= DCD_IDLE;
              bus_own_q <= 1'b0;
            end
          end
        end
        default: begin
          state_q <= DCD_IDLE;
          bus_own_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_strobe_q <= 1'b0;
      bus_write_q <= 1'b0;
      bus_io_q <= 1'b0;
      bus_addr_q <= 20'h00000;
      bus_wdata_q <= 8'h00;
      acc_cnt_q <= 3'h0;
    end else if (launch_rd || launch_wr) begin
      bus_strobe_q <= 1'b1;
      bus_write_q <= launch_wr;
      bus_io_q <= launch_wr ? cur_wr_io : cur_rd_io;
      bus_addr_q <= launch_wr ? cur_wr_addr : cur_rd_addr;
      bus_wdata_q <= launch_wr ? fifo_out_data : 8'h00;
      acc_cnt_q <= acc_load(launch_wr ? cur_wr_io : cur_rd_io, wait_q);
    end else if (acc_done) begin
      bus_strobe_q <= 1'b0;
    end else if (bus_strobe_q) begin
      acc_cnt_q <= acc_cnt_q - 3'h1;
    end
  end

  dcd_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rd_done),
    .in_ready(fifo_in_ready),
    .in_data(bus_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(wr_done),
    .out_data(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register file; engine updates win over software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src0_q <= 19'h00000;
      dst0_q <= 19'h00000;
      cnt0_q <= 16'h0000;
    end else begin
      if (rd_done && !ch_q) begin
        src0_q <= 19'(step_addr({1'b0, src0_q}, cur_rd_step));
      end else if (wr_en && idx == IDX_SRC_LOW) begin
        src0_q[7:0] <= pwdata[7:0];
      end else if (wr_en && idx == IDX_SRC_HIGH) begin
        src0_q[15:8] <= pwdata[7:0];
      end else if (wr_en && idx == IDX_SRC_BANK) begin
        src0_q[18:16] <= pwdata[2:0];
      end
      if (wr_done && !ch_q) begin
        dst0_q <= 19'(step_addr({1'b0, dst0_q}, cur_wr_step));
        cnt0_q <= cnt0_q - 16'h0001;
      end else begin
        if (wr_en && idx == IDX_DST_LOW) begin
          dst0_q[7:0] <= pwdata[7:0];
        end else if (wr_en && idx == IDX_DST_HIGH) begin
          dst0_q[15:8] <= pwdata[7:0];
        end else if (wr_en && idx == IDX_DST_BANK) begin
          dst0_q[18:16] <= pwdata[2:0];
        end
        if (wr_en && idx == IDX_CNT0_LOW) begin
          cnt0_q[7:0] <= pwdata[7:0];
        end else if (wr_en && idx == IDX_CNT0_HIGH) begin
          cnt0_q[15:8] <= pwdata[7:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem1_q <= 20'h00000;
      io1_q <= 16'h0000;
      cnt1_q <= 16'h0000;
    end else begin
      // channel 1 memory step and count; I/O pointer fixed
      if (ch_q && ((rd_done && !cur_rd_io) || (wr_done && !cur_wr_io))) begin
        mem1_q <= step_addr(mem1_q, cur_rd_io ? cur_wr_step : cur_rd_step);
      end else if (wr_en && idx == IDX_MEM1_LOW) begin
        mem1_q[7:0] <= pwdata[7:0];
      end else if (wr_en && idx == IDX_MEM1_HIGH) begin
        mem1_q[15:8] <= pwdata[7:0];
      end else if (wr_en && idx == IDX_MEM1_BANK) begin
        mem1_q[19:16] <= pwdata[3:0];
      end
      if (wr_en && idx == IDX_IO1_LOW) begin
        io1_q[7:0] <= pwdata[7:0];
      end else if (wr_en && idx == IDX_IO1_HIGH) begin
        io1_q[15:8] <= pwdata[7:0];
      end
      if (wr_done && ch_q) begin
        cnt1_q <= cnt1_q - 16'h0001;
      end else if (wr_en && idx == IDX_CNT1_LOW) begin
        cnt1_q[7:0] <= pwdata[7:0];
      end else if (wr_en && idx == IDX_CNT1_HIGH) begin
        cnt1_q[15:8] <= pwdata[7:0];
      end
    end
  end

  // Enable bits drop when the count runs out; the hardware clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= ENABLE_RST;
      mode_q <= MODE_RST;
      wait_q <= WAIT_CTRL_RST;
    end else begin
      if (wr_en && idx == IDX_ENABLE) begin
        enable_q <= pwdata[1:0];
      end
      if (wr_done && !ch_q && cnt0_q == 16'h0001) begin
        enable_q[0] <= 1'b0;
      end
      if (wr_done && ch_q && cnt1_q == 16'h0001) begin
        enable_q[1] <= 1'b0;
      end
      if (wr_en && idx == IDX_MODE) begin
        mode_q <= {2'h0, pwdata[5:1], 1'b0};
      end
      // software chooses zero memory waits when external generators run
      if (wr_en && idx == IDX_WAIT_CTRL) begin
        wait_q <= pwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [2:0] stb_len_q;
  logic [2:0] stb_exp_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_len_q <= 3'h0;
      stb_exp_q <= 3'h0;
    end else if (launch_rd || launch_wr) begin
      stb_len_q <= 3'h0;
      stb_exp_q <= (launch_wr ? cur_wr_io : cur_rd_io)
                   ? (IO_BASE_CYCLES + {1'b0, wait_q[IO_WAIT_LSB+:2]})
                   : (MEM_BASE_CYCLES + {1'b0, wait_q[MEM_WAIT_LSB+:2]});
    end else if (bus_strobe_q) begin
      stb_len_q <= stb_len_q + 3'h1;
    end
  end

  sequence wr_finish_s;
    wr_done && !ch_q && !burst;
  endsequence
  sequence release_s;
    ##2 !bus_own_q;
  endsequence

  wait_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(bus_strobe_q) |-> stb_len_q == $past(stb_exp_q)) else $error("strobe length wrong");
  steal_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_finish_s |-> release_s) else $error("cycle steal kept the bus");
  burst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_own_q && !ch_q && burst && cnt0_q > 16'h0001 |=> bus_own_q)
    else $error("burst dropped the bus early");
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && !ch_q |=> cnt0_q == $past(cnt0_q) - 16'h0001) else $error("count not stepped");
  io_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_strobe_q && ch_q && bus_io_q |-> bus_addr_q[15:0] == io1_q)
    else $error("channel 1 I/O address moved");
  ser_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    start0 && src_io && src0_q[17:16] == SEL_SER0 |-> serial0_rx_full)
    else $error("wrong receive request");
endmodule : dcd_dma_regs

`default_nettype wire

// ==== sim/dcd_partner.sv ====
// Far side of the engine: byte memory on the system bus, request pins, serial flags.
// Assumes the engine's clock and reset; read data is the address byte xor 5a.
`timescale 1ns/1ps
`default_nettype none
module dcd_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic req_on,
  // System bus
  input wire logic bus_own_q,
  input wire logic bus_strobe_q,
  input wire logic bus_write_q,
  input wire logic bus_io_q,
  input wire logic [19:0] bus_addr_q,
  input wire logic [7:0] bus_wdata_q,
  output logic [7:0] bus_rdata,
  // Requests
  output logic ext_request_n,
  output logic serial_flag,
  // Observation
  output logic wr_io,
  output logic [19:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] own_cnt
);
  logic tog_q;
  logic own_prev_q;
  assign ext_request_n = ~req_on;
  assign serial_flag = req_on;
  // Idle bus toggles so a stale byte is never mistaken for data
  assign bus_rdata = (bus_strobe_q && !bus_write_q) ? (bus_addr_q[7:0] ^ 8'h5a) : {8{tog_q}};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 1'b0;
      own_prev_q <= 1'b0;
      own_cnt <= 8'h00;
      wr_io <= 1'b0;
      wr_addr <= 20'h00000;
      wr_data <= 8'h00;
    end else begin
      tog_q <= ~tog_q;
      own_prev_q <= bus_own_q;
      if (bus_own_q && !own_prev_q) own_cnt <= own_cnt + 8'h01;
      if (bus_strobe_q && bus_write_q) begin
        wr_io <= bus_io_q;
        wr_addr <= bus_addr_q;
        wr_data <= bus_wdata_q;
      end
    end
  end
endmodule : dcd_partner
`default_nettype wire

// ==== sim/dcd_dma_regs_test.sv ====
// Bench for the DMA register block: APB register checks, two mem-to-mem runs, a channel 1 mem-to-I/O run and a serial-paced I/O-to-mem run.
// Assumes the partner model answers every strobe at once.
`timescale 1ns/1ps
`default_nettype none
module dcd_dma_regs_test;
  import dcd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, req_on, flag, req_n, err;
  logic own, stb, wr, io, wr_io;
  logic [19:0] addr, wr_addr;
  logic [7:0] wdata, rdata, wr_data, own_cnt;
  logic [31:0] r;
  int n_errors = 0;
  int samples_checked = 0;
  logic [5:0] idx [15] = '{IDX_SRC_LOW, IDX_SRC_HIGH, IDX_SRC_BANK, IDX_DST_LOW, IDX_DST_HIGH,
    IDX_DST_BANK, IDX_CNT0_LOW, IDX_CNT0_HIGH, IDX_MEM1_LOW, IDX_MEM1_HIGH, IDX_MEM1_BANK,
    IDX_IO1_LOW, IDX_IO1_HIGH, IDX_CNT1_LOW, IDX_CNT1_HIGH};
  logic [7:0] msk [15] = '{8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff};
  always #2.5 pclk = ~pclk;
  dcd_dma_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .ext_request_ch0_n(req_n),
    .ext_request_ch1_n(req_n), .serial0_rx_full(flag), .serial1_rx_full(flag),
    .serial0_tx_empty(flag), .serial1_tx_empty(flag), .bus_own_q(own), .bus_strobe_q(stb),
    .bus_write_q(wr), .bus_io_q(io), .bus_addr_q(addr), .bus_wdata_q(wdata),
    .bus_rdata(rdata));
  dcd_partner far (.pclk(pclk), .presetn(presetn), .req_on(req_on), .bus_own_q(own),
    .bus_strobe_q(stb), .bus_write_q(wr), .bus_io_q(io), .bus_addr_q(addr),
    .bus_wdata_q(wdata), .bus_rdata(rdata), .ext_request_n(req_n), .serial_flag(flag),
    .wr_io(wr_io), .wr_addr(wr_addr), .wr_data(wr_data), .own_cnt(own_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_q !== 1'b1 && k < 50);
    if (pready_q !== 1'b1) n_errors++;
    r = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, IDX_ENABLE, 8'h00);
      k++;
    end while (r[2:0] !== 3'h0 && k < 60);
    if (r[2:0] !== 3'h0) n_errors++;
  endtask : wait_idle
  task automatic run(input logic [7:0] mode, input logic [7:0] cnt);
    apb(1'b1, IDX_CNT0_LOW, cnt);
    apb(1'b1, IDX_MODE, mode);
    apb(1'b1, IDX_ENABLE, 8'h01);
    wait_idle;
  endtask : run
  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    req_on <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_WAIT_CTRL, 8'h00);
    chk("wait_ctrl reset", r, {24'h0, WAIT_CTRL_RST});
    apb(1'b1, IDX_WAIT_CTRL, 8'h3f);
    apb(1'b0, IDX_WAIT_CTRL, 8'h00);
    chk("wait_ctrl rw", r, 32'h3f);
    for (int j = 0; j < 15; j++) begin
      apb(1'b1, idx[j], 8'hff);
      apb(1'b0, idx[j], 8'h00);
      chk("reg rw", r, {24'h0, msk[j]});
    end
    apb(1'b1, 6'h2d, 8'hff);
    apb(1'b0, 6'h2d, 8'h00);
    chk("unmapped", {err, r[30:0]}, 32'h80000000);
    // Zero memory waits, as with external chip-select wait generators
    apb(1'b1, IDX_WAIT_CTRL, 8'h00);
    apb(1'b1, IDX_SRC_LOW, 8'h10);
    apb(1'b1, IDX_SRC_HIGH, 8'h01);
    apb(1'b1, IDX_SRC_BANK, 8'h00);
    apb(1'b1, IDX_DST_LOW, 8'h00);
    apb(1'b1, IDX_DST_HIGH, 8'h02);
    apb(1'b1, IDX_DST_BANK, 8'h00);
    apb(1'b1, IDX_CNT0_HIGH, 8'h00);
    run(8'h00, 8'h02);
    chk("steal owns", own_cnt, 8'h02);
    chk("steal write", {wr_io, wr_addr, wr_data}, {1'b0, 20'h00201, 8'h4b});
    apb(1'b0, IDX_SRC_LOW, 8'h00);
    chk("src step", r, 32'h12);
    run(8'h12, 8'h03);
    chk("burst owns", own_cnt, 8'h03);
    chk("burst write", {wr_io, wr_addr, wr_data}, {1'b0, 20'h00200, 8'h4e});
    apb(1'b0, IDX_DST_LOW, 8'h00);
    chk("dst dec", r, 32'hff);
    apb(1'b0, IDX_CNT0_LOW, 8'h00);
    chk("count end", r, 32'h0);
    // Channel 1 memory to I/O: level request held off, then raised
    apb(1'b1, IDX_MEM1_LOW, 8'h50);
    apb(1'b1, IDX_MEM1_HIGH, 8'h01);
    apb(1'b1, IDX_MEM1_BANK, 8'h00);
    apb(1'b1, IDX_IO1_LOW, 8'h34);
    apb(1'b1, IDX_IO1_HIGH, 8'h00);
    apb(1'b1, IDX_CNT1_LOW, 8'h01);
    apb(1'b1, IDX_CNT1_HIGH, 8'h00);
    apb(1'b1, IDX_ENABLE, 8'h02);
    apb(1'b0, IDX_ENABLE, 8'h00);
    chk("no request", r, 32'h2);
    req_on <= 1'b1;
    wait_idle;
    chk("ch1 write", {wr_io, wr_addr, wr_data}, {1'b1, 20'h00034, 8'h0a});
    apb(1'b0, IDX_MEM1_LOW, 8'h00);
    chk("mem1 step", r, 32'h51);
    // Channel 0 I/O source paced by serial 0 receive
    apb(1'b1, IDX_SRC_BANK, 8'h01);
    run(8'h0c, 8'h01);
    chk("rx write", {wr_io, wr_addr, wr_data}, {1'b0, 20'h001ff, 8'h4f});
    apb(1'b0, IDX_SRC_LOW, 8'h00);
    chk("io src fixed", r, 32'h15);
    report_and_stop;
  end
endmodule : dcd_dma_regs_test
`default_nettype wire
